/* File: hdl/ssb_sense_builder.sv */
// Sense record store and Request Sense data-in engine with a plain register port.
`include "ssb_regs.svh"
module ssb_sense_builder (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // Register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Asynchronous event pins
  input  wire logic        UNIT_ATTN_PIN,
  input  wire logic        HW_FAULT_PIN,
  // Command engine events
  input  wire logic        CMD_ABORT,
  // Sense request
  input  wire logic        REQ_START,
  input  wire logic [7:0]  REQ_ALLOC,
  input  wire logic        REQ_FATAL,
  // Data-in byte stream
  output logic             DATA_VALID,
  output logic      [7:0]  DATA_BYTE,
  input  wire logic        DATA_READY,
  // Completion
  output logic             SENSE_DONE,
  output logic             STATUS_CHECK
);

  ssb_pkg::ssb_state_t state_reg;
  ssb_pkg::ssb_key_t   key_reg;
  ssb_pkg::ssb_key_t   key_next;
  ssb_pkg::ssb_key_t   snap_key_reg;
  logic        pend_reg;
  logic        not_ready_reg;
  logic [7:0]  asc_reg;
  logic [7:0]  additional_code_qualifier_reg;
  logic        cd_reg;
  logic        bpv_reg;
  logic [2:0]  bp_reg;
  logic [15:0] fp_reg;
  logic [15:0] fp_stage_reg;
  logic [7:0]  asc_next;
  logic [7:0]  additional_code_qualifier_next;
  logic        cd_next;
  logic        bpv_next;
  logic [2:0]  bp_next;
  logic [15:0] fp_next;
  logic        post_any;
  logic        snap_pend_reg;
  logic [7:0]  snap_asc_reg;
  logic [7:0]  snap_additional_code_qualifier_reg;
  logic        snap_cd_reg;
  logic        snap_bpv_reg;
  logic [2:0]  snap_bp_reg;
  logic [15:0] snap_fp_reg;
  logic [4:0]  idx_reg;
  logic [4:0]  len_reg;
  logic [4:0]  count_reg;
  logic [7:0]  byte_reg;
  logic        done_reg;
  logic        check_reg;
  logic [31:0] rdata_reg;
  logic        ua_s1_reg;
  logic        ua_s2_reg;
  logic        ua_s3_reg;
  logic        hw_s1_reg;
  logic        hw_s2_reg;
  logic        hw_s3_reg;
  logic        ua_event;
  logic        hw_event;
  logic        sw_post;
  logic        sw_clear;
  logic        start_ok;
  logic        accept;
  logic        last;
  logic [4:0]  len_calc;

  // One byte of the eighteen-byte record built from a stored snapshot.
  function automatic logic [7:0] sense_byte(
    input logic [4:0]        idx,
    input logic              pend,
    input ssb_pkg::ssb_key_t key,
    input logic [7:0]        additional_code,
    input logic [7:0]        additional_code_qualifier,
    input logic              cd,
    input logic              bit_pointer_valid,
    input logic [2:0]        bp,
    input logic [15:0]       fp
  );
    logic key_specific_valid;
    key_specific_valid = (key == `SSB_KEY_ILL);
    case (idx)
      5'd0:    sense_byte = {1'b0, pend ? `SSB_ERR_CURRENT : 7'h00};
      5'd1:    sense_byte = `SSB_ZERO8;
      5'd2:    sense_byte = {4'h0, key};
      5'd7:    sense_byte = `SSB_ADD_LEN;
      5'd12:   sense_byte = additional_code;
      5'd13:   sense_byte = additional_code_qualifier;
      5'd14:   sense_byte = `SSB_ZERO8;
      5'd15:   sense_byte = key_specific_valid ? {1'b1, cd, 2'b00, bit_pointer_valid, bp} : `SSB_ZERO8;
      5'd16:   sense_byte = key_specific_valid ? fp[15:8] : `SSB_ZERO8;
      5'd17:   sense_byte = key_specific_valid ? fp[7:0] : `SSB_ZERO8;
      default: sense_byte = `SSB_ZERO8;
    endcase
  endfunction

  // Pins are synchronised; only the second and third stages feed the edge detector.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ua_s1_reg <= 1'b0;
      ua_s2_reg <= 1'b0;
      ua_s3_reg <= 1'b0;
      hw_s1_reg <= 1'b0;
      hw_s2_reg <= 1'b0;
      hw_s3_reg <= 1'b0;
    end else begin
      ua_s1_reg <= UNIT_ATTN_PIN;
      ua_s2_reg <= ua_s1_reg;
      ua_s3_reg <= ua_s2_reg;
      hw_s1_reg <= HW_FAULT_PIN;
      hw_s2_reg <= hw_s1_reg;
      hw_s3_reg <= hw_s2_reg;
    end
  end

  assign ua_event = ua_s2_reg && !ua_s3_reg;
  assign hw_event = hw_s2_reg && !hw_s3_reg;
  assign sw_post  = REG_WR && (REG_ADDR == `SSB_OFF_POST);
  assign sw_clear = REG_WR && (REG_ADDR == `SSB_OFF_CTRL) && REG_WDATA[`SSB_CTRL_CLR];
  assign post_any = hw_event || ua_event || CMD_ABORT || sw_post;

  // The last error wins; simultaneous events rank by severity.
  always_comb begin
    key_next  = key_reg;
    asc_next  = asc_reg;
    additional_code_qualifier_next = additional_code_qualifier_reg;
    cd_next   = 1'b0;
    bpv_next  = 1'b0;
    bp_next   = 3'h0;
    fp_next   = 16'h0000;
    if (hw_event) begin
      key_next  = `SSB_KEY_HW;
      asc_next  = `SSB_ASC_HW;
      additional_code_qualifier_next = `SSB_ZERO8;
    end else if (ua_event) begin
      key_next  = `SSB_KEY_UA;
      asc_next  = `SSB_ASC_UA;
      additional_code_qualifier_next = `SSB_ZERO8;
    end else if (CMD_ABORT) begin
      key_next  = `SSB_KEY_ABORT;
      asc_next  = `SSB_ASC_ABORT;
      additional_code_qualifier_next = `SSB_ZERO8;
    end else if (sw_post) begin
      key_next  = REG_WDATA[`SSB_POST_KEY_LO +: 4];
      asc_next  = REG_WDATA[`SSB_POST_ASC_LO +: 8];
      additional_code_qualifier_next = REG_WDATA[`SSB_POST_ADDITIONAL_CODE_QUALIFIER_LO +: 8];
      if (key_next == `SSB_KEY_ILL) begin
        cd_next  = REG_WDATA[`SSB_POST_CD];
        bpv_next = REG_WDATA[`SSB_POST_BPV];
        bp_next  = bpv_next ? REG_WDATA[`SSB_POST_BP_LO +: 3] : 3'h0;
        fp_next  = fp_stage_reg;
      end
    end
  end

  // Stored error; a new event in the clearing cycle survives the clear.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_reg <= 1'b0;
      key_reg  <= `SSB_KEY_NONE;
      asc_reg  <= `SSB_ZERO8;
      additional_code_qualifier_reg <= `SSB_ZERO8;
      cd_reg   <= 1'b0;
      bpv_reg  <= 1'b0;
      bp_reg   <= 3'h0;
      fp_reg   <= 16'h0000;
    end else if (post_any) begin
      pend_reg <= 1'b1;
      key_reg  <= key_next;
      asc_reg  <= asc_next;
      additional_code_qualifier_reg <= additional_code_qualifier_next;
      cd_reg   <= cd_next;
      bpv_reg  <= bpv_next;
      bp_reg   <= bp_next;
      fp_reg   <= fp_next;
    end else if (sw_clear || (accept && last)) begin
      pend_reg <= 1'b0;
      key_reg  <= `SSB_KEY_NONE;
      asc_reg  <= `SSB_ZERO8;
      additional_code_qualifier_reg <= `SSB_ZERO8;
      cd_reg   <= 1'b0;
      bpv_reg  <= 1'b0;
      bp_reg   <= 3'h0;
      fp_reg   <= 16'h0000;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      not_ready_reg <= 1'b0;
      fp_stage_reg  <= 16'h0000;
    end else if (REG_WR) begin
      if (REG_ADDR == `SSB_OFF_CTRL) begin
        not_ready_reg <= REG_WDATA[`SSB_CTRL_NRDY];
      end
      if (REG_ADDR == `SSB_OFF_FIELD) begin
        fp_stage_reg <= REG_WDATA[15:0];
      end
    end
  end

  assign start_ok = REQ_START && (state_reg == ssb_pkg::SSB_IDLE) && !REQ_FATAL;
  assign len_calc = (REQ_ALLOC < {3'h0, `SSB_REC_LEN}) ? REQ_ALLOC[4:0] : `SSB_REC_LEN;
  assign accept   = (state_reg == ssb_pkg::SSB_SEND) && DATA_READY;
  assign last     = (idx_reg == len_reg - 5'd1);

  // Snapshot taken at the start so a mid-transfer post cannot tear the record.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      snap_pend_reg <= 1'b0;
      snap_key_reg  <= `SSB_KEY_NONE;
      snap_asc_reg  <= `SSB_ZERO8;
      snap_additional_code_qualifier_reg <= `SSB_ZERO8;
      snap_cd_reg   <= 1'b0;
      snap_bpv_reg  <= 1'b0;
      snap_bp_reg   <= 3'h0;
      snap_fp_reg   <= 16'h0000;
    end else if (start_ok) begin
      snap_pend_reg <= pend_reg;
      snap_cd_reg   <= cd_reg;
      snap_bpv_reg  <= bpv_reg;
      snap_bp_reg   <= bp_reg;
      snap_fp_reg   <= fp_reg;
      if (!pend_reg && not_ready_reg) begin
        snap_key_reg  <= `SSB_KEY_NRDY;
        snap_asc_reg  <= `SSB_ASC_NRDY;
        snap_additional_code_qualifier_reg <= `SSB_ZERO8;
      end else begin
        snap_key_reg  <= key_reg;
        snap_asc_reg  <= asc_reg;
        snap_additional_code_qualifier_reg <= additional_code_qualifier_reg;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ssb_pkg::SSB_IDLE;
      idx_reg   <= 5'h00;
      len_reg   <= 5'h00;
      count_reg <= 5'h00;
      done_reg  <= 1'b0;
      check_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ssb_pkg::SSB_IDLE: begin
          if (REQ_START && REQ_FATAL) begin
            done_reg  <= 1'b1;
            check_reg <= 1'b1;
            count_reg <= 5'h00;
          end else if (start_ok) begin
            idx_reg   <= 5'h00;
            len_reg   <= len_calc;
            count_reg <= 5'h00;
            check_reg <= 1'b0;
            if (len_calc == 5'h00) begin
              done_reg <= 1'b1;
            end else begin
              state_reg <= ssb_pkg::SSB_SEND;
            end
          end
        end
        ssb_pkg::SSB_SEND: begin
          if (accept) begin
            idx_reg   <= idx_reg + 5'd1;
            count_reg <= count_reg + 5'd1;
            if (last) begin
              state_reg <= ssb_pkg::SSB_IDLE;
              done_reg  <= 1'b1;
              check_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= ssb_pkg::SSB_IDLE;
        end
      endcase
    end
  end

  // While DATA_VALID is high the byte register holds the byte at the current index.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      byte_reg <= `SSB_ZERO8;
    end else if (start_ok) begin
      byte_reg <= sense_byte(5'h00, pend_reg, (!pend_reg && not_ready_reg) ? `SSB_KEY_NRDY : key_reg,
                             asc_reg, additional_code_qualifier_reg, cd_reg, bpv_reg, bp_reg, fp_reg);
    end else if (accept && !last) begin
      byte_reg <= sense_byte(idx_reg + 5'd1, snap_pend_reg, snap_key_reg, snap_asc_reg,
                             snap_additional_code_qualifier_reg, snap_cd_reg, snap_bpv_reg, snap_bp_reg, snap_fp_reg);
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= `SSB_ZERO32;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `SSB_OFF_CTRL:   rdata_reg <= {31'h0000_0000, not_ready_reg};
        `SSB_OFF_FIELD:  rdata_reg <= {16'h0000, fp_stage_reg};
        `SSB_OFF_STATUS: rdata_reg <= {24'h00_0000, key_reg, 1'b0, check_reg,
                                       state_reg == ssb_pkg::SSB_SEND, pend_reg};
        `SSB_OFF_COUNT:  rdata_reg <= {27'h000_0000, count_reg};
        default:         rdata_reg <= `SSB_ZERO32;
      endcase
    end else begin
      rdata_reg <= `SSB_ZERO32;
    end
  end

  assign REG_RDATA    = rdata_reg;
  assign DATA_VALID   = (state_reg == ssb_pkg::SSB_SEND);
  assign DATA_BYTE    = byte_reg;
  assign SENSE_DONE   = done_reg;
  assign STATUS_CHECK = check_reg;

  a_fatal_check: assert property (@(posedge MCLK) disable iff (!RSTN)
    (REQ_START && REQ_FATAL && state_reg == ssb_pkg::SSB_IDLE) |=> (SENSE_DONE && STATUS_CHECK && !DATA_VALID))
    else $error("fatal sense request did not end with check condition");
  a_zero_alloc: assert property (@(posedge MCLK) disable iff (!RSTN)
    (start_ok && REQ_ALLOC == 8'h00) |=> (SENSE_DONE && !STATUS_CHECK && !DATA_VALID))
    else $error("zero allocation still sent data");
  a_good_end: assert property (@(posedge MCLK) disable iff (!RSTN)
    (accept && last) |=> (SENSE_DONE && !STATUS_CHECK && !DATA_VALID))
    else $error("sense transfer did not end with good status");
  a_trunc_count: assert property (@(posedge MCLK) disable iff (!RSTN)
    (SENSE_DONE && !STATUS_CHECK) |-> (count_reg == len_reg || len_reg == 5'h00))
    else $error("byte count differs from truncated length");
  a_seg_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
    (DATA_VALID && idx_reg == 5'd1) |-> (DATA_BYTE == 8'h00))
    else $error("segment byte not zero");
  a_flags_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
    (DATA_VALID && idx_reg == 5'd2) |-> (DATA_BYTE[7:4] == 4'h0 && DATA_BYTE[3:0] == snap_key_reg))
    else $error("byte two flags not zero or key wrong");
  a_info_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
    (DATA_VALID && ((idx_reg >= 5'd3 && idx_reg <= 5'd6) || (idx_reg >= 5'd8 && idx_reg <= 5'd11)))
    |-> (DATA_BYTE == 8'h00))
    else $error("information bytes not zero");
  a_fru_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
    (DATA_VALID && idx_reg == 5'd14) |-> (DATA_BYTE == 8'h00))
    else $error("unit code byte not zero");
  a_add_len: assert property (@(posedge MCLK) disable iff (!RSTN)
    (DATA_VALID && idx_reg == 5'd7) |-> (DATA_BYTE == 8'h0A))
    else $error("additional length byte wrong");
  a_key_specific_valid_key: assert property (@(posedge MCLK) disable iff (!RSTN)
    (DATA_VALID && idx_reg == 5'd15) |-> (DATA_BYTE[7] == (snap_key_reg == 4'h5)))
    else $error("key specific valid disagrees with key");
  a_err_code: assert property (@(posedge MCLK) disable iff (!RSTN)
    (DATA_VALID && idx_reg == 5'd0) |-> (DATA_BYTE == (snap_pend_reg ? 8'h70 : 8'h00)))
    else $error("error code byte wrong");
  a_byte_order: assert property (@(posedge MCLK) disable iff (!RSTN)
    (accept && !last) |=> (DATA_VALID && idx_reg == $past(idx_reg) + 5'd1))
    else $error("sense bytes not in ascending order");
  a_hw_key: assert property (@(posedge MCLK) disable iff (!RSTN)
    hw_event |=> (pend_reg && key_reg == 4'h4))
    else $error("hardware fault not stored as key 4");

endmodule // ssb_sense_builder

/* File: common/ssb_regs.svh */
// Register offsets, field positions and fixed sense values of the sense data builder.
`ifndef SSB_REGS_SVH
`define SSB_REGS_SVH
`define SSB_OFF_CTRL      8'h00
`define SSB_OFF_POST      8'h04
`define SSB_OFF_FIELD     8'h08
`define SSB_OFF_STATUS    8'h0C
`define SSB_OFF_COUNT     8'h10
`define SSB_CTRL_NRDY     0
`define SSB_CTRL_CLR      1
`define SSB_POST_KEY_LO   0
`define SSB_POST_ASC_LO   8
`define SSB_POST_ADDITIONAL_CODE_QUALIFIER_LO  16
`define SSB_POST_CD       24
`define SSB_POST_BPV      25
`define SSB_POST_BP_LO    28
`define SSB_REC_LEN       5'h12
`define SSB_IDX_LAST      5'h11
`define SSB_ERR_CURRENT   7'h70
`define SSB_ADD_LEN       8'h0A
`define SSB_KEY_NONE      4'h0
`define SSB_KEY_NRDY      4'h2
`define SSB_KEY_HW        4'h4
`define SSB_KEY_ILL       4'h5
`define SSB_KEY_UA        4'h6
`define SSB_KEY_ABORT     4'hB
`define SSB_ASC_NRDY      8'h04
`define SSB_ASC_HW        8'h44
`define SSB_ASC_UA        8'h28
`define SSB_ASC_ABORT     8'h00
`define SSB_ZERO8         8'h00
`define SSB_ZERO32        32'h0000_0000
`endif

/* File: common/ssb_pkg.sv */
// Types shared by the sense data builder.
package ssb_pkg;
  typedef enum logic [1:0] {
    SSB_IDLE = 2'b01,
    SSB_SEND = 2'b10
  } ssb_state_t;
  typedef logic [3:0] ssb_key_t;
endpackage

/* File: test/ssb_initiator_model.sv */
// Initiator model that accepts the data-in byte stream, with an optional stalling pattern.
module ssb_initiator_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Byte stream
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            ready,
  // Bench control
  input  wire logic       stall,
  input  wire logic       clear
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [0:31];
  int         count;
  // Element address request block as this host would issue it; the device side decodes only the sense request.
  function automatic logic [95:0] elem_addr_cdb(input logic [15:0] start, input logic [15:0] num,
                                                input logic [23:0] alloc);
    elem_addr_cdb = {8'hB5, 8'h00, start, num, 8'h00, alloc, 8'h00, 8'h00};
  endfunction
  // A stalling host drops ready every other cycle, so each byte must hold until it is taken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      count <= 0;
    end else begin
      ready <= stall ? !ready : 1'b1;
      if (clear) begin
        count <= 0;
      end else if (valid && ready && count < 32) begin
        got[count] <= data;
        count      <= count + 1;
      end
    end
  end
endmodule // ssb_initiator_model

/* File: test/ssb_sense_builder_bench.sv */
// Self-checking bench for the sense data builder.
module ssb_sense_builder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK, RSTN, REG_WR, REG_RD, UNIT_ATTN_PIN, HW_FAULT_PIN, CMD_ABORT;
  logic        REQ_START, REQ_FATAL, DATA_VALID, DATA_READY, SENSE_DONE, STATUS_CHECK;
  logic        m_stall, m_clear, e_pend;
  logic [3:0]  e_key;
  logic [7:0]  REG_ADDR, REQ_ALLOC, DATA_BYTE, e_asc, e_additional_code_qualifier, e_sks;
  logic [15:0] e_fp;
  logic [31:0] REG_WDATA, REG_RDATA, rdv;
  logic [3:0]  ev_key [4] = '{4'h4, 4'h6, 4'hB, 4'hB};
  logic [7:0]  ev_asc [4] = '{8'h44, 8'h28, 8'h00, 8'h47};
  int          fails, comparisons;

  ssb_sense_builder dut_u (.MCLK, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .UNIT_ATTN_PIN,
    .HW_FAULT_PIN, .CMD_ABORT, .REQ_START, .REQ_ALLOC, .REQ_FATAL, .DATA_VALID, .DATA_BYTE, .DATA_READY,
    .SENSE_DONE, .STATUS_CHECK);
  ssb_initiator_model partner_u (.clk(MCLK), .rst_n(RSTN), .valid(DATA_VALID), .data(DATA_BYTE),
    .ready(DATA_READY), .stall(m_stall), .clear(m_clear));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken, so sample just past that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  task automatic post(input logic [3:0] k, input logic [7:0] c, input logic [7:0] q, input logic cd,
                      input logic bit_pointer_valid, input logic [2:0] bp);
    wr(8'h04, {1'b0, bp, 2'b00, bit_pointer_valid, cd, q, c, 4'h0, k});
  endtask

  task automatic expect_rec(input logic p, input logic [3:0] k, input logic [7:0] c, input logic [7:0] q,
                            input logic [7:0] s, input logic [15:0] f);
    e_pend = p;
    e_key  = k;
    e_asc  = c;
    e_additional_code_qualifier = q;
    e_sks  = s;
    e_fp   = f;
  endtask

  function automatic logic [7:0] exp_byte(input int i);
    case (i)
      0: return e_pend ? 8'h70 : 8'h00;
      2: return {4'h0, e_key};
      7: return 8'h0A;
      12: return e_asc;
      13: return e_additional_code_qualifier;
      15: return e_sks;
      16: return e_fp[15:8];
      17: return e_fp[7:0];
      default: return 8'h00;
    endcase
  endfunction

  task automatic sense(input logic [7:0] alloc, input logic f, input logic chk);
    int n;
    int k;
    n = (f || alloc == 8'h00) ? 0 : (alloc > 8'h12 ? 18 : int'(alloc));
    @(posedge MCLK);
    REQ_START <= 1'b1;
    REQ_ALLOC <= alloc;
    REQ_FATAL <= f;
    m_clear   <= 1'b1;
    @(posedge MCLK);
    REQ_START <= 1'b0;
    m_clear   <= 1'b0;
    #1 check(32'(DATA_VALID), 32'(n != 0));
    k = 0;
    while (SENSE_DONE !== 1'b1 && k < 200) begin
      @(posedge MCLK);
      #1 k++;
    end
    check(32'(SENSE_DONE), 32'h0000_0001);
    check(32'(STATUS_CHECK), 32'(chk));
    check(32'(partner_u.count), 32'(n));
    for (int i = 0; i < n; i++) begin
      check(32'(partner_u.got[i]), 32'(exp_byte(i)));
    end
  endtask

  initial begin
    repeat (20000) @(posedge MCLK);
    fails++;
    tally_and_finish;
  end

  initial begin
    {RSTN, REG_WR, REG_RD, UNIT_ATTN_PIN, HW_FAULT_PIN, CMD_ABORT, REQ_START, REQ_FATAL} = '0;
    {m_stall, m_clear, REG_ADDR, REQ_ALLOC, REG_WDATA} = '0;
    repeat (3) @(posedge MCLK);
    RSTN <= 1'b1;
    expect_rec(1'b0, 4'h0, 8'h00, 8'h00, 8'h00, 16'h0000);
    sense(8'h12, 1'b0, 1'b0);
    rd(8'h20, rdv);
    check(rdv, 32'h0000_0000);
    $display("test idle record done");
    wr(8'h00, 32'h0000_0001);
    rd(8'h00, rdv);
    check(rdv, 32'h0000_0001);
    expect_rec(1'b0, 4'h2, 8'h04, 8'h00, 8'h00, 16'h0000);
    sense(8'h12, 1'b0, 1'b0);
    wr(8'h00, 32'h0000_0000);
    $display("test not ready done");
    wr(8'h08, 32'h0000_0102);
    rd(8'h08, rdv);
    check(rdv, 32'h0000_0102);
    post(4'h5, 8'h24, 8'h00, 1'b1, 1'b1, 3'h5);
    expect_rec(1'b1, 4'h5, 8'h24, 8'h00, 8'hCD, 16'h0102);
    m_stall <= 1'b1;
    sense(8'h12, 1'b0, 1'b0);
    m_stall <= 1'b0;
    expect_rec(1'b0, 4'h0, 8'h00, 8'h00, 8'h00, 16'h0000);
    sense(8'h12, 1'b0, 1'b0);
    wr(8'h08, 32'h0000_0007);
    post(4'h5, 8'h26, 8'h01, 1'b0, 1'b0, 3'h7);
    expect_rec(1'b1, 4'h5, 8'h26, 8'h01, 8'h80, 16'h0007);
    sense(8'h11, 1'b0, 1'b0);
    $display("test illegal request done");
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      case (i)
        0: HW_FAULT_PIN <= 1'b1;
        1: UNIT_ATTN_PIN <= 1'b1;
        2: CMD_ABORT <= 1'b1;
        default: post(4'hB, 8'h47, 8'h00, 1'b1, 1'b1, 3'h3);
      endcase
      @(posedge MCLK);
      CMD_ABORT <= 1'b0;
      repeat (6) @(posedge MCLK);
      HW_FAULT_PIN  <= 1'b0;
      UNIT_ATTN_PIN <= 1'b0;
      expect_rec(1'b1, ev_key[i], ev_asc[i], 8'h00, 8'h00, 16'h0000);
      sense(8'h12, 1'b0, 1'b0);
    end
    $display("test event keys done");
    post(4'h6, 8'h28, 8'h00, 1'b0, 1'b0, 3'h0);
    expect_rec(1'b1, 4'h6, 8'h28, 8'h00, 8'h00, 16'h0000);
    sense(8'h12, 1'b1, 1'b1);
    rd(8'h0C, rdv);
    check(rdv & 32'h0000_00F5, 32'h0000_0065);
    sense(8'h00, 1'b0, 1'b0);
    sense(8'h05, 1'b0, 1'b0);
    rd(8'h10, rdv);
    check(rdv & 32'h0000_001F, 32'h0000_0005);
    rd(8'h0C, rdv);
    check(rdv & 32'h0000_0001, 32'h0000_0000);
    post(4'hB, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0);
    rd(8'h0C, rdv);
    check(rdv & 32'h0000_00F1, 32'h0000_00B1);
    wr(8'h00, 32'h0000_0002);
    rd(8'h0C, rdv);
    check(rdv & 32'h0000_0001, 32'h0000_0000);
    $display("test fatal and truncation done");
    tally_and_finish;
  end
endmodule // ssb_sense_builder_bench
